// [hw/wdt_fetch_trap.sv]
// Watchdog timer with address trap on instruction fetches
//
// Function
// - Watchdog runs straight out of reset
// - Overflow gives reset or interrupt by select
// - Counting pauses in stop, idle, sleep
// - Clear code clears binary stages only
// - Detection code picks overflow period
// - Interrupt select locks until hardware reset
// - Control one write-only; reads return a fixed fill
// - Code port decodes clear, disable, commit
// - Disable code works only with enable cleared
// - Stages held cleared while disabled
// - Watchdog interrupt is non-maskable
// - Watchdog interrupts nest without limit
// - Internal reset lasts at most 24 periods
// - Fetch from register area always traps
// - RAM trap select needs commit code
// - Trap action bit picks interrupt or reset
// - Trap interrupt non-maskable and preempting
`timescale 1ns/100ps
module wdt_fetch_trap
    import wdt_trap_pkg::*;
#(
    parameter int HI_EXP0 = 25,
    parameter int LO_EXP0 = 17,
    parameter logic [15:0] SFR_LO = 16'h0000,
    parameter logic [15:0] SFR_HI = 16'h003F,
    parameter logic [15:0] RAM_LO = 16'h0040,
    parameter logic [15:0] RAM_HI = 16'h023F
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic hclk_tick,
    input wire logic lclk_tick,
    input wire logic slow_mode,
    input wire logic divider_clock_select,
    input wire logic stop_mode,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_addr,
    output logic watchdog_interrupt,
    output logic fetch_trap_interrupt,
    output logic internal_reset,
    output logic watchdog_running
);
    localparam int DIV_W = HI_EXP0 - EXP_STEP;

    // Control state
    logic enable_bit_ff;
    logic active_ff;
    logic [1:0] time_sel_ff;
    logic ovf_sel_ff;
    logic ram_sel_ff;
    logic ram_trap_on_ff;
    logic trap_act_ff;

    // Output registers
    logic [7:0] rdata_ff;
    logic wdt_irq_ff;
    logic trap_irq_ff;
    logic int_rst_ff;
    rst_state_t rst_state_ff;
    rst_state_t nxt_rst_state;
    logic [4:0] rst_cnt_ff;
    logic [4:0] nxt_rst_cnt;

    // Decoded strobes and events
    logic wr_ctrl;
    logic wr_code;
    logic code_clear;
    logic code_disable;
    logic code_commit;
    logic use_high;
    logic src_tick;
    logic paused;
    logic run;
    logic ovf;
    logic [STAGE_BITS-1:0] bin_cnt;
    logic [4:0] tap_exp;
    logic in_sfr;
    logic in_ram;
    logic trap_ev;
    logic rst_req;

    // Address window test used for both trap areas
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // Stage tap exponent: a quarter of the selected period
    function automatic logic [4:0] stage_exp(input logic hi, input logic [1:0] sel);
        int base;
        base = hi ? HI_EXP0 : LO_EXP0;
        return 5'(base - EXP_STEP * int'(sel) - EXP_STEP);
    endfunction

    // Register port decode
    always_comb begin
        wr_ctrl = 1'b0;
        wr_code = 1'b0;
        if (reg_wr && (reg_addr == CTRL_ONE_ADDR)) begin
            wr_ctrl = 1'b1;
        end else if (reg_wr && (reg_addr == CODE_PORT_ADDR)) begin
            wr_code = 1'b1;
        end
    end

    // Code decode; other values do nothing
    assign code_clear = wr_code && (reg_wdata == CODE_CLEAR);
    assign code_disable = wr_code && (reg_wdata == CODE_DISABLE);
    assign code_commit = wr_code && (reg_wdata == CODE_TRAP_COMMIT);

    // Clock source and period selection
    assign use_high = !slow_mode && !divider_clock_select;
    assign src_tick = use_high ? hclk_tick : lclk_tick;
    assign tap_exp = stage_exp(use_high, time_sel_ff);

    // Counting pauses in low-power modes
    assign paused = stop_mode || idle_mode || sleep_mode;
    assign run = active_ff && !paused;

    wdt_stage_counter #(
        .DIV_W(DIV_W)
    ) u_stage (
        .mclk(mclk),
        .rst_b(rst_b),
        .src_tick(src_tick),
        .run(run),
        .hold_clr(!active_ff),
        .clr_bin(code_clear),
        .tap_exp(tap_exp),
        .ovf_ff(ovf),
        .bin_ff(bin_cnt)
    );

    // Detection time field
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            time_sel_ff <= RST_TIME;
        end else if (wr_ctrl) begin
            time_sel_ff <= reg_wdata[F_TIME_HI:F_TIME_LO];
        end
    end

    // Overflow action select; once cleared it cannot be set again
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ovf_sel_ff <= RST_OVF_SEL;
        end else if (wr_ctrl) begin
            ovf_sel_ff <= ovf_sel_ff && reg_wdata[F_OVF_SEL];
        end
    end

    // Enable bit as written by software
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            enable_bit_ff <= RST_ENABLE;
        end else if (wr_ctrl) begin
            enable_bit_ff <= reg_wdata[F_ENABLE];
        end
    end

    // Running state: set by the enable bit, dropped only by disable code
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            active_ff <= RST_ENABLE;
        end else if (wr_ctrl && reg_wdata[F_ENABLE]) begin
            active_ff <= 1'b1;
        end else if (code_disable && !enable_bit_ff) begin
            active_ff <= 1'b0;
        end
    end

    // Trap action select
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trap_act_ff <= RST_TRAP_ACT;
        end else if (wr_ctrl) begin
            trap_act_ff <= reg_wdata[F_TRAP_ACT];
        end
    end

    // RAM trap select: staged, then committed by code
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ram_sel_ff <= RST_RAM_TRAP;
        end else if (wr_ctrl) begin
            ram_sel_ff <= reg_wdata[F_RAM_TRAP];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ram_trap_on_ff <= RST_RAM_TRAP;
        end else if (code_commit) begin
            ram_trap_on_ff <= ram_sel_ff;
        end
    end

    // Reads: both registers are write-only, data is a fixed fill
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= READ_FILL;
        end else if (reg_rd) begin
            rdata_ff <= READ_FILL;
        end else begin
            rdata_ff <= READ_FILL;
        end
    end

    // Fetch trap detection
    assign in_sfr = in_range(fetch_addr, SFR_LO, SFR_HI);
    assign in_ram = in_range(fetch_addr, RAM_LO, RAM_HI);
    assign trap_ev = fetch_valid && (in_sfr || (in_ram && ram_trap_on_ff));

    // Non-maskable interrupt pulses; raised on every event whose select picks interrupt
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_irq_ff <= 1'b0;
            trap_irq_ff <= 1'b0;
        end else begin
            wdt_irq_ff <= ovf && !ovf_sel_ff;
            trap_irq_ff <= trap_ev && !trap_act_ff;
        end
    end

    // Internal reset pulse generator
    assign rst_req = (ovf && ovf_sel_ff) || (trap_ev && trap_act_ff);

    always_comb begin
        nxt_rst_state = rst_state_ff;
        nxt_rst_cnt = rst_cnt_ff;
        case (rst_state_ff)
            RS_IDLE: begin
                if (rst_req) begin
                    nxt_rst_state = RS_HOLD;
                    nxt_rst_cnt = RST_CYC;
                end
            end
            RS_HOLD: begin
                if (rst_cnt_ff <= RST_CNT_ONE) begin
                    nxt_rst_state = RS_IDLE;
                    nxt_rst_cnt = RST_CNT_ZERO;
                end else begin
                    nxt_rst_cnt = rst_cnt_ff - RST_CNT_ONE;
                end
            end
            default: begin
                nxt_rst_state = RS_IDLE;
                nxt_rst_cnt = RST_CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_state_ff <= RS_IDLE;
            rst_cnt_ff <= RST_CNT_ZERO;
            int_rst_ff <= 1'b0;
        end else begin
            rst_state_ff <= nxt_rst_state;
            rst_cnt_ff <= nxt_rst_cnt;
            int_rst_ff <= (nxt_rst_state == RS_HOLD);
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = rdata_ff;
    assign watchdog_interrupt = wdt_irq_ff;
    assign fetch_trap_interrupt = trap_irq_ff;
    assign internal_reset = int_rst_ff;
    assign watchdog_running = active_ff;

    // Length of the current reset pulse, for checking only
    logic [5:0] rst_len_ff;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_len_ff <= '0;
        end else begin
            rst_len_ff <= int_rst_ff ? rst_len_ff + 1'b1 : '0;
        end
    end

    property p_start_running;
        @(posedge mclk) disable iff (!rst_b)
        $rose(rst_b) |-> active_ff && ovf_sel_ff;
    endproperty
    a_start_running: assert property (p_start_running) else $error("watchdog not running after reset");

    property p_ovf_reset;
        @(posedge mclk) disable iff (!rst_b)
        (ovf && ovf_sel_ff && rst_state_ff == RS_IDLE) |=> internal_reset && !watchdog_interrupt;
    endproperty
    a_ovf_reset: assert property (p_ovf_reset) else $error("overflow did not reset");

    property p_ovf_irq;
        @(posedge mclk) disable iff (!rst_b)
        (ovf && !ovf_sel_ff) |=> watchdog_interrupt;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow did not interrupt");

    property p_sel_lock;
        @(posedge mclk) disable iff (!rst_b)
        !ovf_sel_ff |=> !ovf_sel_ff;
    endproperty
    a_sel_lock: assert property (p_sel_lock) else $error("output select returned to reset");

    property p_disable_guard;
        @(posedge mclk) disable iff (!rst_b)
        (code_disable && enable_bit_ff && active_ff) |=> active_ff;
    endproperty
    a_disable_guard: assert property (p_disable_guard) else $error("disable code acted with enable set");

    property p_disable_act;
        @(posedge mclk) disable iff (!rst_b)
        (code_disable && !enable_bit_ff && !wr_ctrl) |=> !active_ff ##1 (bin_cnt == STAGE_ZERO);
    endproperty
    a_disable_act: assert property (p_disable_act) else $error("disable code ignored");

    property p_commit;
        @(posedge mclk) disable iff (!rst_b)
        code_commit |=> (ram_trap_on_ff == $past(ram_sel_ff));
    endproperty
    a_commit: assert property (p_commit) else $error("RAM trap select not committed");

    property p_sfr_trap;
        @(posedge mclk) disable iff (!rst_b)
        (fetch_valid && in_sfr && !trap_act_ff) |=> fetch_trap_interrupt;
    endproperty
    a_sfr_trap: assert property (p_sfr_trap) else $error("fetch from register area not trapped");

    property p_trap_reset;
        @(posedge mclk) disable iff (!rst_b)
        (trap_ev && trap_act_ff && rst_state_ff == RS_IDLE) |=> internal_reset && !fetch_trap_interrupt;
    endproperty
    a_trap_reset: assert property (p_trap_reset) else $error("trap did not reset");

    property p_rst_len;
        @(posedge mclk) disable iff (!rst_b)
        $fell(internal_reset) |-> (rst_len_ff <= 6'(RST_CYC));
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("internal reset too long");
endmodule // wdt_fetch_trap

// [common/wdt_trap_pkg.sv]
// Shared constants for the watchdog and fetch-trap block
package wdt_trap_pkg;
    // Register map (byte addresses on the plain port)
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h34;
    localparam logic [7:0] CODE_PORT_ADDR = 8'h35;
    // Codes accepted by the code port
    localparam logic [7:0] CODE_CLEAR = 8'h4E;
    localparam logic [7:0] CODE_DISABLE = 8'hB1;
    localparam logic [7:0] CODE_TRAP_COMMIT = 8'hD2;
    // Field positions in watchdog_control_one
    localparam int F_RAM_TRAP = 5;
    localparam int F_TRAP_ACT = 4;
    localparam int F_ENABLE = 3;
    localparam int F_TIME_HI = 2;
    localparam int F_TIME_LO = 1;
    localparam int F_OVF_SEL = 0;
    // Reset values of the fields
    localparam logic RST_RAM_TRAP = 1'b1;
    localparam logic RST_TRAP_ACT = 1'b1;
    localparam logic RST_ENABLE = 1'b1;
    localparam logic [1:0] RST_TIME = 2'h0;
    localparam logic RST_OVF_SEL = 1'b1;
    // Value returned by any read
    localparam logic [7:0] READ_FILL = 8'h00;
    // Two-stage binary counter
    localparam int STAGE_BITS = 2;
    localparam logic [STAGE_BITS-1:0] STAGE_TOP = 2'h3;
    localparam logic [STAGE_BITS-1:0] STAGE_ZERO = 2'h0;
    // Exponent step between detection codes and stage share of period
    localparam int EXP_STEP = 2;
    // Timing of the internal reset pulse
    localparam int CLK_PERIOD_NS = 25;
    localparam int RST_FC_PERIODS = 24;
    localparam int RST_TIME_NS = RST_FC_PERIODS * CLK_PERIOD_NS;
    localparam int RST_CYC_INT = (RST_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : RST_TIME_NS / CLK_PERIOD_NS;
    localparam logic [4:0] RST_CYC = 5'(RST_CYC_INT);
    localparam logic [4:0] RST_CNT_ZERO = 5'h00;
    localparam logic [4:0] RST_CNT_ONE = 5'h01;
    // Reset pulse state machine
    typedef enum logic [1:0] {
        RS_IDLE = 2'b01,
        RS_HOLD = 2'b10
    } rst_state_t;
endpackage

// [hw/wdt_stage_counter.sv]
// Prescaling divider and two-stage binary counter of the watchdog
`timescale 1ns/100ps
module wdt_stage_counter
    import wdt_trap_pkg::*;
#(
    parameter int DIV_W = 23
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic src_tick,
    input wire logic run,
    input wire logic hold_clr,
    input wire logic clr_bin,
    input wire logic [4:0] tap_exp,
    output logic ovf_ff,
    output logic [STAGE_BITS-1:0] bin_ff
);
    logic [DIV_W-1:0] div_ff;
    logic stage_tick;

    // Mask of divider bits that must all be ones for a stage step
    function automatic logic [DIV_W-1:0] tap_mask(input logic [4:0] k);
        logic [DIV_W-1:0] m;
        m = '0;
        for (int i = 0; i < DIV_W; i++) begin
            m[i] = (i < int'(k));
        end
        return m;
    endfunction

    assign stage_tick = run && src_tick && ((div_ff & tap_mask(tap_exp)) == tap_mask(tap_exp));

    // Divider: frozen while paused, never cleared by the clear code
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_ff <= '0;
        end else if (run && src_tick) begin
            div_ff <= div_ff + 1'b1;
        end
    end

    // Binary stages: cleared by code or while disabled, held when paused
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bin_ff <= STAGE_ZERO;
        end else if (hold_clr || clr_bin) begin
            bin_ff <= STAGE_ZERO;
        end else if (stage_tick) begin
            bin_ff <= bin_ff + 1'b1;
        end
    end

    // Overflow pulse when the top stage wraps
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ovf_ff <= 1'b0;
        end else begin
            ovf_ff <= stage_tick && !hold_clr && !clr_bin && (bin_ff == STAGE_TOP);
        end
    end

    property p_pause_hold;
        @(posedge mclk) disable iff (!rst_b)
        (!run && !hold_clr && !clr_bin) |=> $stable(bin_ff) && $stable(div_ff);
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("count moved while paused");

    property p_clear_bin_only;
        @(posedge mclk) disable iff (!rst_b)
        (clr_bin && run && src_tick) |=> (bin_ff == STAGE_ZERO) && (div_ff == $past(div_ff) + 1'b1);
    endproperty
    a_clear_bin_only: assert property (p_clear_bin_only) else $error("clear code touched divider");

    property p_disabled_zero;
        @(posedge mclk) disable iff (!rst_b)
        hold_clr [*2] |-> (bin_ff == STAGE_ZERO) && !ovf_ff;
    endproperty
    a_disabled_zero: assert property (p_disabled_zero) else $error("stages not cleared while disabled");
endmodule // wdt_stage_counter

// [testbench/cpu_fetch_model.sv]
// Instruction-fetch side of the on-chip CPU, as seen by the trap unit
`timescale 1ns/100ps
module cpu_fetch_model (
    input wire logic mclk,
    input wire logic go,
    input wire logic [15:0] addr,
    output logic fetch_valid,
    output logic [15:0] fetch_addr
);
    logic [15:0] last_ff = 16'h0000;
    // Fetch strobe follows the request for exactly its cycles
    assign fetch_valid = go;
    // Idle bus shows the inverted last address so stale values never match
    assign fetch_addr = go ? addr : ~last_ff;
    // Remember the last presented address
    always @(posedge mclk) begin
        if (go) begin
            last_ff <= addr;
        end
    end
endmodule // cpu_fetch_model

// [testbench/test_wdt_fetch_trap.sv]
// Self-checking bench for the watchdog and fetch-trap block
`timescale 1ns/100ps
module test_wdt_fetch_trap;
    import wdt_trap_pkg::*;
    localparam int HI_E = 10;
    localparam int LO_E = 8;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic hclk_tick = 1'b1;
    logic lclk_tick = 1'b0;
    logic lclk_run = 1'b0;
    logic slow_mode = 1'b0;
    logic divider_clock_select = 1'b0;
    logic stop_mode = 1'b0;
    logic idle_mode = 1'b0;
    logic sleep_mode = 1'b0;
    logic f_go = 1'b0;
    logic [15:0] f_addr = 16'h0000;
    logic fetch_valid;
    logic [15:0] fetch_addr;
    logic watchdog_interrupt;
    logic fetch_trap_interrupt;
    logic internal_reset;
    logic watchdog_running;
    logic [7:0] rd;
    int miscompares = 0;
    int tests_run = 0;
    int n_wdi = 0;
    int n_fti = 0;
    int base;

    wdt_fetch_trap #(.HI_EXP0(HI_E), .LO_EXP0(LO_E)) u_dut (
        .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hclk_tick(hclk_tick),
        .lclk_tick(lclk_tick), .slow_mode(slow_mode), .divider_clock_select(divider_clock_select),
        .stop_mode(stop_mode), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .watchdog_interrupt(watchdog_interrupt),
        .fetch_trap_interrupt(fetch_trap_interrupt), .internal_reset(internal_reset),
        .watchdog_running(watchdog_running)
    );
    cpu_fetch_model u_cpu (
        .mclk(mclk), .go(f_go), .addr(f_addr), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr)
    );

    // 40 MHz clock
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // Pulse counters and low-clock tick every other cycle
    always @(posedge mclk) begin
        if (watchdog_interrupt === 1'b1) n_wdi++;
        if (fetch_trap_interrupt === 1'b1) n_fti++;
        lclk_tick <= lclk_run & ~lclk_tick;
    end

    task automatic summarize;
        $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
        end
    endtask
    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic fetch(input logic [15:0] a, input logic [15:0] b, input int n);
        @(posedge mclk);
        f_go <= 1'b1;
        f_addr <= a;
        if (n > 1) begin
            @(posedge mclk);
            f_addr <= b;
        end
        @(posedge mclk);
        f_go <= 1'b0;
        #1;
    endtask
    // Wait for reset (sel 1) or interrupt (sel 0), then check its length
    task automatic measure(input logic sel, input int lo, input int hi, input int wexp);
        int n;
        int w;
        n = 0;
        w = 0;
        #1;
        while ((sel ? internal_reset : watchdog_interrupt) !== 1'b1 && n <= hi) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk_rng(n, lo, hi);
        while ((sel ? internal_reset : watchdog_interrupt) === 1'b1 && w < 40) begin
            w++;
            @(posedge mclk);
            #1;
        end
        chk_rng(w, wexp, wexp);
    endtask

    // Main sequence
    initial begin
        do_reset();
        #1 chk_val(8'(watchdog_running), 8'h01);
        reg_read(CTRL_ONE_ADDR, rd);
        chk_val(rd, READ_FILL);
        reg_read(8'h40, rd);
        chk_val(rd, READ_FILL);
        // Every detection code in reset mode
        for (int c = 0; c < 4; c++) begin
            reg_write(CTRL_ONE_ADDR, 8'h39 | 8'(c << 1));
            reg_write(CODE_PORT_ADDR, CODE_CLEAR);
            measure(1'b1, (3 << (HI_E - 2 * c)) / 4, (1 << (HI_E - 2 * c)) + 4, 24);
            do_reset();
        end
        // Fetch traps with reset defaults, then as interrupts with RAM trap committed off
        fetch(16'h0010, 16'h0000, 1);
        measure(1'b1, 0, 0, 24);
        do_reset();
        fetch(16'h023F, 16'h0000, 1);
        measure(1'b1, 0, 0, 24);
        do_reset();
        reg_write(CODE_PORT_ADDR, CODE_CLEAR);
        reg_write(CTRL_ONE_ADDR, 8'h09);
        base = n_fti;
        fetch(16'h0040, 16'h0000, 1);
        @(posedge mclk);
        #1 chk_rng(n_fti - base, 1, 1);
        reg_write(CODE_PORT_ADDR, CODE_TRAP_COMMIT);
        fetch(16'h0040, 16'h0000, 1);
        @(posedge mclk);
        #1 chk_rng(n_fti - base, 1, 1);
        fetch(16'h0020, 16'h003F, 2);
        @(posedge mclk);
        #1 chk_rng(n_fti - base, 3, 3);
        chk_val(8'(internal_reset), 8'h00);
        // Interrupt mode, stack assumed set up first
        reg_write(CTRL_ONE_ADDR, 8'h2E);
        reg_write(CODE_PORT_ADDR, CODE_CLEAR);
        measure(1'b0, 12, 20, 1);
        measure(1'b0, 14, 17, 1);
        reg_write(CTRL_ONE_ADDR, 8'h2F);
        reg_write(CODE_PORT_ADDR, CODE_CLEAR);
        measure(1'b0, 12, 20, 1);
        chk_val(8'(internal_reset), 8'h00);
        // Stop, idle and sleep each hold the count
        for (int m = 0; m < 3; m++) begin
            reg_write(CODE_PORT_ADDR, CODE_CLEAR);
            repeat (3) @(posedge mclk);
            stop_mode <= (m == 0);
            idle_mode <= (m == 1);
            sleep_mode <= (m == 2);
            base = n_wdi;
            repeat (100) @(posedge mclk);
            #1 chk_rng(n_wdi - base, 0, 0);
            @(posedge mclk);
            stop_mode <= 1'b0;
            idle_mode <= 1'b0;
            sleep_mode <= 1'b0;
            measure(1'b0, 6, 18, 1);
        end
        // Clearing inside three quarters of the period keeps it quiet
        base = n_wdi;
        for (int k = 0; k < 6; k++) begin
            reg_write(CODE_PORT_ADDR, CODE_CLEAR);
            repeat (8) @(posedge mclk);
        end
        #1 chk_rng(n_wdi - base, 0, 0);
        // Disable code refused while enabled, then the proper sequence
        reg_write(CODE_PORT_ADDR, CODE_DISABLE);
        repeat (2) @(posedge mclk);
        #1 chk_val(8'(watchdog_running), 8'h01);
        reg_write(CODE_PORT_ADDR, CODE_CLEAR);
        reg_write(CTRL_ONE_ADDR, 8'h26);
        reg_write(CODE_PORT_ADDR, CODE_DISABLE);
        repeat (2) @(posedge mclk);
        #1 chk_val(8'(watchdog_running), 8'h00);
        base = n_wdi;
        repeat (100) @(posedge mclk);
        #1 chk_rng(n_wdi - base, 0, 0);
        reg_write(CTRL_ONE_ADDR, 8'h2E);
        measure(1'b0, 12, 20, 1);
        chk_val(8'(watchdog_running), 8'h01);
        // Low clock through divider select, then slow mode
        reg_write(CTRL_ONE_ADDR, 8'h28);
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            lclk_run <= 1'b1;
            divider_clock_select <= (k == 0);
            slow_mode <= (k == 1);
            reg_write(CODE_PORT_ADDR, CODE_CLEAR);
            measure(1'b0, 3 << (LO_E - 1), (1 << (LO_E + 1)) + 8, 1);
        end
        summarize();
    end

    // Hang guard
    initial begin
        #1000000;
        miscompares++;
        summarize();
    end
endmodule // test_wdt_fetch_trap
